/* amp_ctrl_model.sv */
`timescale 1ns/1ps
module amp_ctrl_model #(
    parameter int HOLD = 8
) (
    // Clock and bench requests
    input wire logic core_clk,
    input wire logic resetReq,
    input wire logic [3:0] pwmStop,
    // Indicator wires
    input wire logic faultWire,
    input wire logic warnWire,
    // Drive to the device
    output logic resetN,
    output logic [3:0] pwm
);
    logic [7:0] sinceFall = 8'hFF;
    logic faultPrev = 1'b1;
    logic [2:0] div = 3'h0;
    initial resetN = 1'b1;
    // Reset is released only when cool and after the settle delay
    always @(posedge core_clk) begin
        faultPrev <= faultWire;
        div <= div + 3'h1;
        if (faultPrev && !faultWire) begin
            sinceFall <= 8'h00;
        end else if (sinceFall != 8'hFF) begin
            sinceFall <= sinceFall + 8'h01;
        end
        if (resetReq) begin
            resetN <= 1'b0;
        end else if (warnWire && sinceFall >= HOLD) begin
            resetN <= 1'b1;
        end
    end
    // Idle frames run on every channel that is not stopped
    assign pwm = {4{div[2]}} & ~pwmStop;
endmodule

/* amp_fault_cfg.svh */
`ifndef AMP_FAULT_CFG_SVH
`define AMP_FAULT_CFG_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define OLP_TIME_NS 2600000
// Pin-short check time, split evenly over the ground and supply steps
`define PSC_TIME_NS 15000000
`define PWM_GAP_NS 10000
`define PWM_GAP_CYCLES ((`PWM_GAP_NS) / (`CLK_PERIOD_NS))
`define CNT_W 20
`define GAP_W 12

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define CTRL_ADDR 32'h00000000
`define STATUS_ADDR 32'h00000004
`define CTRL_RESET 3'h0
`define CTRL_CFG_LSB 0
`define CTRL_OC_BIT 2
`define ST_PSC_LSB 0
`define ST_THERM_BIT 2
`define ST_FAULT_BIT 3
`define ST_WARN_BIT 4
`define ST_OLP_LSB 8
`define ST_OC_LSB 12
`define ST_NOPWM_LSB 16
`define ST_HIZ_LSB 20
`define ST_HSOFF_LSB 24
`define ST_RESET_BIT 28
`define ST_UV_BIT 29
`define ST_FPIN_BIT 30
`define ST_WPIN_BIT 31

`endif

/* amp_fault_pkg.sv */
package amp_fault_pkg;

`include "amp_fault_cfg.svh"

    typedef enum logic [1:0] {
        PSC_POWER_UP,
        PSC_SHORT_GND,
        PSC_SHORT_SUPPLY,
        PSC_RUN
    } psc_state_t;

    typedef enum logic [1:0] {
        CFG_BRIDGE_TIED,
        CFG_PARALLEL_BRIDGE,
        CFG_SINGLE_ENDED
    } out_cfg_t;

    // Levels arriving from comparators and pins, all asynchronous
    typedef struct packed {
        logic resetN;
        logic [3:0] pwm;
        logic [2:0] uv;
        logic por;
        logic supplyUp;
        logic [3:0] bootUv;
        logic tempWarn;
        logic tempOver;
        logic [3:0] curLimit;
        logic [3:0] overCur;
        logic [3:0] shortGnd;
        logic [3:0] shortSup;
        logic faultPin;
        logic warnPin;
    } pins_t;

    typedef struct packed {
        logic [3:0] hiZ;
        logic [3:0] highSideOff;
        logic [3:0] flip;
    } stage_t;

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        logic [3:0] pwmPrev;
        logic resetPrev;
        psc_state_t psc;
        logic [`CNT_W-1:0] stepCnt;
        logic [3:0][`CNT_W-1:0] olpCnt;
        logic [3:0][`GAP_W-1:0] gapCnt;
        logic [3:0] noPwm;
        logic [3:0] olpLatch;
        logic [3:0] ocLatch;
        logic [3:0] flipQ;
        logic thermalLatch;
        logic [1:0] cfg;
        logic latchOc;
        stage_t stage;
        logic faultOe;
        logic warnOe;
        logic odLevel;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } state_t;

endpackage

/* amp_fault_protection_control.sv */
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "amp_fault_cfg.svh"

module amp_fault_protection_control #(
    parameter int unsigned OLP_CYCLES =
        (`OLP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int unsigned PSC_STEP_CYCLES =
        `PSC_TIME_NS / 2 / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Detector and pin levels
    input amp_fault_pkg::pins_t pinsIn,
    // Power stage control
    output amp_fault_pkg::stage_t stageOut,
    // Open-drain indicators
    output logic faultOut,
    output logic faultOe,
    output logic warnOut,
    output logic warnOe
);

    // ---------------------------------------------------------------
    // State and derived terms
    // ---------------------------------------------------------------
    amp_fault_pkg::state_t q;
    amp_fault_pkg::state_t n;
    amp_fault_pkg::pins_t p;
    logic resetRise;
    logic uvAny;
    logic inCheck;
    logic startOk;
    logic mono;
    logic single;
    logic globalOff;
    logic faultReport;
    logic [3:0] pwmEdge;
    logic [3:0] chanFault;
    logic [3:0] groupOff;
    logic accessPhase;
    logic [31:0] statusWord;

    assign p = q.s2;
    assign resetRise = p.resetN & ~q.resetPrev;
    assign uvAny = (|p.uv) | p.por;
    assign inCheck = (q.psc == amp_fault_pkg::PSC_SHORT_GND) ||
                     (q.psc == amp_fault_pkg::PSC_SHORT_SUPPLY);
    assign startOk = p.supplyUp & ~uvAny;
    assign mono = (q.cfg == amp_fault_pkg::CFG_PARALLEL_BRIDGE);
    assign single = (q.cfg == amp_fault_pkg::CFG_SINGLE_ENDED);
    assign pwmEdge = p.pwm & ~q.pwmPrev;
    assign chanFault = q.olpLatch | q.ocLatch | q.noPwm;
    assign accessPhase = psel & penable;

    // ---------------------------------------------------------------
    // Shutdown decisions
    // ---------------------------------------------------------------
    // Global shutdown covers supply, thermal, missing PWM on all four half-bridges, start-up and reset
    assign globalOff = uvAny | q.thermalLatch | (&q.noPwm) |
                       (q.psc != amp_fault_pkg::PSC_RUN) |
                       ~p.resetN;

    always_comb begin
        if (mono) begin
            groupOff = {4{|chanFault}};
        end else begin
            groupOff = {{2{|chanFault[3:2]}},
                        {2{|chanFault[1:0]}}};
        end
    end

    // Missing PWM is silent, so only these count toward the pin
    assign faultReport = uvAny | q.thermalLatch | (|q.olpLatch) |
                         (|q.ocLatch);

    always_comb begin
        statusWord = 32'h00000000;
        statusWord[`ST_PSC_LSB +: 2] = q.psc;
        statusWord[`ST_THERM_BIT] = q.thermalLatch;
        statusWord[`ST_FAULT_BIT] = q.faultOe;
        statusWord[`ST_WARN_BIT] = q.warnOe;
        statusWord[`ST_OLP_LSB +: 4] = q.olpLatch;
        statusWord[`ST_OC_LSB +: 4] = q.ocLatch;
        statusWord[`ST_NOPWM_LSB +: 4] = q.noPwm;
        statusWord[`ST_HIZ_LSB +: 4] = q.stage.hiZ;
        statusWord[`ST_HSOFF_LSB +: 4] = q.stage.highSideOff;
        statusWord[`ST_RESET_BIT] = p.resetN;
        statusWord[`ST_UV_BIT] = uvAny;
        statusWord[`ST_FPIN_BIT] = p.faultPin;
        statusWord[`ST_WPIN_BIT] = p.warnPin;
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        n = q;
        n.s1 = pinsIn;
        n.s2 = q.s1;
        n.pwmPrev = p.pwm;
        n.resetPrev = p.resetN;

        // Start-up pin-short check, driven by the supply only
        case (q.psc)
            amp_fault_pkg::PSC_POWER_UP: begin
                n.stepCnt = '0;
                n.olpLatch = 4'h0;
                if (startOk) begin
                    if (single) begin
                        n.psc = amp_fault_pkg::PSC_RUN;
                    end else begin
                        n.psc = amp_fault_pkg::PSC_SHORT_GND;
                    end
                end
            end
            amp_fault_pkg::PSC_SHORT_GND: begin
                if (|p.shortGnd) begin
                    n.stepCnt = '0;
                end else if (q.stepCnt ==
                             `CNT_W'(PSC_STEP_CYCLES - 1)) begin
                    n.stepCnt = '0;
                    n.psc = amp_fault_pkg::PSC_SHORT_SUPPLY;
                end else begin
                    n.stepCnt = q.stepCnt + `CNT_W'(1);
                end
            end
            amp_fault_pkg::PSC_SHORT_SUPPLY: begin
                if (|p.shortSup) begin
                    n.stepCnt = '0;
                end else if (q.stepCnt ==
                             `CNT_W'(PSC_STEP_CYCLES - 1)) begin
                    n.stepCnt = '0;
                    n.psc = amp_fault_pkg::PSC_RUN;
                end else begin
                    n.stepCnt = q.stepCnt + `CNT_W'(1);
                end
            end
            amp_fault_pkg::PSC_RUN: begin
                n.stepCnt = '0;
            end
            default: begin
                n.psc = amp_fault_pkg::PSC_POWER_UP;
            end
        endcase
        // Loss of the main supply means the next start-up checks again
        if (!p.supplyUp) begin
            n.psc = amp_fault_pkg::PSC_POWER_UP;
        end

        // Latched faults: a new event wins over the reset rising edge
        n.thermalLatch = p.tempOver |
                         (q.thermalLatch & ~resetRise);

        for (int i = 0; i < 4; i++) begin
            // Overload timer counts persistent limiting
            if (!q.latchOc && p.curLimit[i]) begin
                if (q.olpCnt[i] != `CNT_W'(OLP_CYCLES - 1)) begin
                    n.olpCnt[i] = q.olpCnt[i] + `CNT_W'(1);
                end
            end else begin
                n.olpCnt[i] = '0;
            end
            if (q.psc != amp_fault_pkg::PSC_POWER_UP) begin
                n.olpLatch[i] = (!q.latchOc && p.curLimit[i] &&
                    q.olpCnt[i] == `CNT_W'(OLP_CYCLES - 1)) ||
                    (q.olpLatch[i] && !resetRise);
            end
            n.ocLatch[i] = (q.latchOc && p.overCur[i]) ||
                           (q.ocLatch[i] && !resetRise);

            // Limiting mode: toggle on each PWM period, so fs/2
            if (!q.latchOc && p.curLimit[i]) begin
                if (pwmEdge[i]) begin
                    n.flipQ[i] = ~q.flipQ[i];
                end
            end else begin
                n.flipQ[i] = 1'b0;
            end

            // PWM watchdog per half-bridge
            if (pwmEdge[i]) begin
                n.gapCnt[i] = '0;
                n.noPwm[i] = 1'b0;
            end else if (q.gapCnt[i] == `GAP_W'(`PWM_GAP_CYCLES - 1)) begin
                n.noPwm[i] = 1'b1;
            end else begin
                n.gapCnt[i] = q.gapCnt[i] + `GAP_W'(1);
            end
        end

        // Power stage and indicators
        n.stage.hiZ = {4{globalOff}} | groupOff;
        n.stage.highSideOff = p.bootUv;
        n.stage.flip = q.flipQ;
        n.faultOe = inCheck ||
                    (p.resetN && faultReport);
        n.warnOe = p.tempWarn | q.thermalLatch;
        n.odLevel = 1'b0;

        // APB: one wait state, answer registered
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        if (accessPhase && !q.pready) begin
            n.pready = 1'b1;
            if (paddr == `CTRL_ADDR) begin
                n.prdata = {29'h00000000, q.latchOc, q.cfg};
            end else if (paddr == `STATUS_ADDR) begin
                n.prdata = statusWord;
            end else begin
                n.prdata = 32'h00000000;
                n.pslverr = 1'b1;
            end
        end
        if (accessPhase && q.pready && pwrite &&
            paddr == `CTRL_ADDR) begin
            n.cfg = pwdata[`CTRL_CFG_LSB +: 2];
            n.latchOc = pwdata[`CTRL_OC_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
            q.s1.resetN <= 1'b0;
            q.s2.resetN <= 1'b0;
            q.psc <= amp_fault_pkg::PSC_POWER_UP;
            {q.latchOc, q.cfg} <= `CTRL_RESET;
            q.stage.hiZ <= 4'hF;
        end else begin
            q <= n;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign stageOut = q.stage;
    assign faultOut = q.odLevel;
    assign faultOe = q.faultOe;
    assign warnOut = q.odLevel;
    assign warnOe = q.warnOe;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence sThermTrip;
        q.thermalLatch ##1 (&q.stage.hiZ);
    endsequence

    sequence sCheckPass;
        (q.psc == amp_fault_pkg::PSC_SHORT_SUPPLY) ##1
        (q.psc == amp_fault_pkg::PSC_RUN);
    endsequence

    a_reset_hiz:
        assert property (!p.resetN |=> &q.stage.hiZ)
        else $error("reset low did not force all half-bridges off");

    a_reset_fault_high:
        assert property (!p.resetN && !inCheck |=> !q.faultOe)
        else $error("fault indicator low while reset held");

    a_check_fault_low:
        assert property (inCheck |=> q.faultOe)
        else $error("fault indicator released during pin-short check");

    a_check_release:
        assert property (sCheckPass ##0 (p.resetN && !faultReport &&
                         $past(p.resetN) && !$past(faultReport))
                         |=> !q.faultOe)
        else $error("fault indicator held after check passed");

    a_pair_off:
        assert property (!mono && q.olpLatch[0] |=>
                         q.stage.hiZ[1] && $past(q.stage.hiZ[1]) == 1'b0
                         || q.stage.hiZ[1])
        else $error("partner half-bridge kept running");

    a_mono_all_off:
        assert property (mono && (|chanFault) |=> &q.stage.hiZ)
        else $error("mono channel fault left a half-bridge on");

    a_boot_silent:
        assert property (p.bootUv[0] && !faultReport && !inCheck
                         |=> q.stage.highSideOff[0] && !q.faultOe)
        else $error("bootstrap undervoltage handled wrongly");

    a_single_skip:
        assert property (q.psc == amp_fault_pkg::PSC_POWER_UP &&
                         startOk && single
                         |=> q.psc == amp_fault_pkg::PSC_RUN)
        else $error("pin-short check ran in single-ended setup");

    a_run_stays:
        assert property (q.psc == amp_fault_pkg::PSC_RUN && p.supplyUp
                         |=> q.psc == amp_fault_pkg::PSC_RUN)
        else $error("start-up sequence restarted without supply loss");

    a_thermal_trip:
        assert property (p.tempOver |=> sThermTrip)
        else $error("thermal shutdown not latched");

    a_olp_trip:
        assert property (!q.latchOc && p.curLimit[2] &&
                         q.olpCnt[2] == `CNT_W'(OLP_CYCLES - 1) &&
                         q.psc != amp_fault_pkg::PSC_POWER_UP
                         |=> q.olpLatch[2] ##1 q.stage.hiZ[3])
        else $error("overload did not latch after limit time");

    a_uv_global:
        assert property (uvAny |=> &q.stage.hiZ && q.faultOe ||
                         &q.stage.hiZ && !$past(p.resetN))
        else $error("undervoltage not handled globally");

    a_warn_low:
        assert property (p.tempWarn |=> q.warnOe)
        else $error("temperature warning not shown");

endmodule

/* amp_fault_protection_control_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin \
    fails++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module amp_fault_protection_control_tb;
    // --------
    // Signals
    // --------
    localparam int OVERLOAD_TRIP = 20;
    localparam int PSC = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, err, resetN, fOut, fOe, wOut, wOe;
    logic [31:0] prdata, rd;
    logic [2:0] uv = 3'h0;
    logic por = 1'b1;
    logic supUp = 1'b0;
    logic tWarn = 1'b0;
    logic tOver = 1'b0;
    logic resetReq = 1'b0;
    logic [3:0] bootUv = 4'h0;
    logic [3:0] curLim = 4'h0;
    logic [3:0] overCur = 4'h0;
    logic [3:0] shGnd = 4'h0;
    logic [3:0] shSup = 4'h0;
    logic [3:0] pwmStop = 4'h0;
    logic [3:0] pwm;
    amp_fault_pkg::stage_t stage;
    amp_fault_pkg::pins_t pins;
    int fails = 0;
    int cmpCount = 0;
    int ch;
    logic f0;
    // Open-drain wires with pull-ups
    wire logic fW = fOe ? fOut : 1'b1;
    wire logic wW = wOe ? wOut : 1'b1;
    assign pins = {resetN, pwm, uv, por, supUp, bootUv, tWarn, tOver,
        curLim, overCur, shGnd, shSup, fW, wW};

    amp_fault_protection_control #(
        .OLP_CYCLES(OVERLOAD_TRIP),
        .PSC_STEP_CYCLES(PSC)
    ) DUT (
        .core_clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pinsIn(pins), .stageOut(stage), .faultOut(fOut),
        .faultOe(fOe), .warnOut(wOut), .warnOe(wOe)
    );
    amp_ctrl_model ctrl (
        .core_clk(clk), .resetReq(resetReq), .pwmStop(pwmStop),
        .faultWire(fW), .warnWire(wW), .resetN(resetN), .pwm(pwm)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    // --------
    // Helpers
    // --------
    function automatic logic [3:0] expHiz(input int cfg, input int c);
        if (cfg == 1) return 4'hF;
        return (c < 2) ? 4'h3 : 4'hC;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic clearFaults();
        int n;
        resetReq <= 1'b1;
        tick(5);
        `CHK("faultOe", 1'b0, fOe)
        `CHK("hiZ", 4'hF, stage.hiZ)
        resetReq <= 1'b0;
        n = 0;
        while (resetN !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        tick(8);
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // --------
    // Tests
    // --------
    initial begin
        void'($urandom(32'h819F0051));
        tick(10);
        rst <= 1'b0;
        por <= 1'b0;
        tick(2);
        apb(1'b0, 32'h0, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        apb(1'b0, 32'h40, 32'h0);
        `CHK("pslverr", 1'b1, err)
        ch = $urandom % 4;
        supUp <= 1'b1;
        shGnd[ch] <= 1'b1;
        tick(30);
        apb(1'b0, 32'h4, 32'h0);
        `CHK("psc", 2'h1, rd[1:0])
        `CHK("hiZ", 4'hF, stage.hiZ)
        resetReq <= 1'b1;
        tick(6);
        `CHK("faultOe", 1'b1, fOe)
        resetReq <= 1'b0;
        tick(4);
        shGnd <= 4'h0;
        tick(15);
        apb(1'b0, 32'h4, 32'h0);
        `CHK("psc", 2'h2, rd[1:0])
        tick(30);
        apb(1'b0, 32'h4, 32'h0);
        `CHK("psc", 2'h3, rd[1:0])
        `CHK("faultOe", 1'b0, fOe)
        `CHK("hiZ", 4'h0, stage.hiZ)
        clearFaults();
        apb(1'b0, 32'h4, 32'h0);
        `CHK("psc", 2'h3, rd[1:0])
        shSup[ch] <= 1'b1;
        tick(6);
        `CHK("hiZ", 4'h0, stage.hiZ)
        shSup <= 4'h0;
        uv[$urandom % 3] <= 1'b1;
        tick(6);
        `CHK("hiZ", 4'hF, stage.hiZ)
        `CHK("faultOe", 1'b1, fOe)
        `CHK("faultPin", 1'b0, fW)
        `CHK("warnOe", 1'b0, wOe)
        uv <= 3'h0;
        tick(40);
        `CHK("hiZ", 4'h0, stage.hiZ)
        bootUv[ch] <= 1'b1;
        tick(6);
        `CHK("hsOff", 4'h1 << ch, stage.highSideOff)
        `CHK("faultOe", 1'b0, fOe)
        bootUv <= 4'h0;
        tick(6);
        `CHK("hsOff", 4'h0, stage.highSideOff)
        tWarn <= 1'b1;
        tick(6);
        `CHK("warnOe", 1'b1, wOe)
        `CHK("warnPin", 1'b0, wW)
        `CHK("faultOe", 1'b0, fOe)
        `CHK("hiZ", 4'h0, stage.hiZ)
        tWarn <= 1'b0;
        tick(6);
        `CHK("warnOe", 1'b0, wOe)
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, 32'h0, 32'h4 | 32'(c));
            ch = $urandom % 4;
            overCur[ch] <= 1'b1;
            tick(4);
            overCur <= 4'h0;
            tick(6);
            `CHK("hiZ", expHiz(c, ch), stage.hiZ)
            `CHK("faultOe", 1'b1, fOe)
            clearFaults();
            `CHK("hiZ", 4'h0, stage.hiZ)
        end
        apb(1'b1, 32'h0, 32'h0);
        curLim[ch] <= 1'b1;
        tick(8);
        `CHK("faultOe", 1'b0, fOe)
        `CHK("hiZ", 4'h0, stage.hiZ)
        // One PWM period holds exactly one rising edge
        f0 = stage.flip[ch];
        tick(8);
        `CHK("flip", ~f0, stage.flip[ch])
        tick(OVERLOAD_TRIP + 6);
        curLim <= 4'h0;
        tick(6);
        `CHK("hiZ", expHiz(0, ch), stage.hiZ)
        `CHK("faultOe", 1'b1, fOe)
        apb(1'b1, 32'h0, 32'h2);
        supUp <= 1'b0;
        tick(6);
        apb(1'b0, 32'h4, 32'h0);
        `CHK("olp", 4'h0, rd[11:8])
        supUp <= 1'b1;
        tick(6);
        apb(1'b0, 32'h4, 32'h0);
        `CHK("psc", 2'h3, rd[1:0])
        apb(1'b1, 32'h0, 32'h0);
        pwmStop[ch] <= 1'b1;
        tick(215);
        `CHK("hiZ", 1'b1, stage.hiZ[ch])
        `CHK("faultOe", 1'b0, fOe)
        pwmStop <= 4'hF;
        tick(215);
        `CHK("hiZ", 4'hF, stage.hiZ)
        pwmStop <= 4'h0;
        tick(20);
        `CHK("hiZ", 4'h0, stage.hiZ)
        tOver <= 1'b1;
        tWarn <= 1'b1;
        tick(6);
        `CHK("hiZ", 4'hF, stage.hiZ)
        `CHK("warnOe", 1'b1, wOe)
        tOver <= 1'b0;
        tWarn <= 1'b0;
        tick(6);
        `CHK("faultOe", 1'b1, fOe)
        resetReq <= 1'b1;
        tick(5);
        `CHK("faultOe", 1'b0, fOe)
        give_verdict();
    end

    initial begin
        tick(6000);
        fails++;
        $display("[ERR] watchdog exp done got hang");
        give_verdict();
    end
endmodule
